// ---- hw/acp_command_port.sv ----
// Functional notes
// - four byte locations at switch-selected base
// - value write clears done flag to zero
// - done flag set once response is placed
// - status byte zero ok, 0x0d reset code, other nonzero error
// - reset code reported after power-up or reset
// - on-command mode: fresh conversion per read
// - continuous mode scans channels plus cold junction
// - reset command repeats full power-up sequence
// - init selects line frequency and scan mode
// - channel pointer selects target, sixteen channels
// - unassigned channel is never converted
// - type code selects range and conversion time
// - value multiplied by slope, default one
// - offset added after slope, default zero
// - signed reading, low byte then high byte
`timescale 1ns/1ps
`include "acp_map.svh"

// cycle counts follow the clock period; override them for short runs
module acp_command_port #(
    parameter int unsigned RESET_CYCLES =
        `ACP_T_RESET_MS * (`ACP_NS_PER_MS / `ACP_CLK_PERIOD_NS),
    parameter int unsigned V14_CYCLES   =
        `ACP_T_V14_MS * (`ACP_NS_PER_MS / `ACP_CLK_PERIOD_NS),
    parameter int unsigned V12_CYCLES   =
        `ACP_T_V12_MS * (`ACP_NS_PER_MS / `ACP_CLK_PERIOD_NS),
    parameter int unsigned TC_CYCLES    =
        `ACP_T_TC_MS * (`ACP_NS_PER_MS / `ACP_CLK_PERIOD_NS)
) (
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [5:0]  BASE_ADDRESS_SWITCH,
    input  wire logic [15:0] FE_DATA,
    output logic             FE_START,
    output logic      [4:0]  FE_CHAN,
    output logic      [7:0]  FE_TYPE,
    output logic             LINE_FREQ_50HZ,
    output logic             CONT_SCAN,
    output logic             CMD_DONE,
    input  wire logic        CLOCK,
    input  wire logic        RESETN
);

    acp_pkg::acp_top_s q;
    acp_pkg::acp_top_s d;

    // timer outputs and per-cycle helpers of the command engine
    logic              conv_busy;
    logic              conv_done;
    logic [15:0]       conv_data;
    logic              hit;
    logic              wr_value;
    logic signed [31:0] product;
    logic [15:0]       scaled;
    logic [3:0]        cidx;
    logic [3:0]        rd_chan;
    logic [7:0]        sts;
    logic              finish;

    // ----------------------------------------------------------------
    // conversion slot timer
    // ----------------------------------------------------------------
    acp_conv_timer #(
        .V14_CYCLES (V14_CYCLES),
        .V12_CYCLES (V12_CYCLES),
        .TC_CYCLES  (TC_CYCLES)
    ) u_conv (
        .clock    (CLOCK),
        .resetn   (RESETN),
        .start    (q.conv_go),
        .chan     (q.conv_chan),
        .ctype    (q.conv_type),
        .fe_data  (FE_DATA),
        .busy     (conv_busy),
        .done     (conv_done),
        .data     (conv_data),
        .fe_start (FE_START),
        .fe_chan  (FE_CHAN),
        .fe_type  (FE_TYPE)
    );

    // ----------------------------------------------------------------
    // host access and command engine
    // ----------------------------------------------------------------
    always_comb
    begin
        d        = q;
        d.sw1    = BASE_ADDRESS_SWITCH;
        d.sw2    = q.sw1;
        d.rdata  = 8'h00;
        d.conv_go = 1'b0;
        sts      = `ACP_STS_OK;
        finish   = 1'b0;
        cidx     = q.conv_chan[3:0];
        rd_chan  = q.loc1[3:0];
        // scaling: slope first, then offset; wraps to 16 bits
        product  = $signed(conv_data) * $signed(q.slope[cidx]);
        scaled   = product[15:0] + q.offset[cidx];

        hit      = (ADDR[7:2] == q.sw2);
        wr_value = WR && hit && (ADDR[1:0] == `ACP_LOC_VALUE);

        if (RD && hit)
        begin
            // reads have no side effects, any order is harmless
            case (ADDR[1:0])
                `ACP_LOC_STATUS: d.rdata = q.loc0;
                `ACP_LOC_ARG:    d.rdata = q.loc1;
                `ACP_LOC_VALUE:  d.rdata = q.loc2;
                default:         d.rdata = {7'h00, q.ready};
            endcase
        end

        if (WR && hit)
        begin
            case (ADDR[1:0])
                `ACP_LOC_STATUS: d.loc0 = WDATA;
                `ACP_LOC_ARG:    d.loc1 = WDATA;
                `ACP_LOC_VALUE:
                begin
                    d.loc2  = WDATA;
                    d.ready = 1'b0;
                    d.pend  = 1'b1;
                end
                default:         d.loc0 = d.loc0; // done flag is read-only
            endcase
        end

        // ----------------------------------------------------------------
        // command state machine
        // ----------------------------------------------------------------
        case (q.st)
            acp_pkg::ST_RESET:
            begin
                if (q.cnt == 32'h0)
                begin
                    // same end state for power-up and reset command
                    d.ctype     = '0;
                    d.slope     = {`ACP_NUM_CHAN{`ACP_SLOPE_RESET}};
                    d.offset    = {`ACP_NUM_CHAN{`ACP_OFFSET_RESET}};
                    d.result    = '0;
                    d.cj        = 16'h0000;
                    d.chan_ptr  = 4'h0;
                    d.line50    = 1'b0;
                    d.scan_mode = 1'b0;
                    d.scan_idx  = 5'h00;
                    d.loc0      = `ACP_STS_RESET;
                    d.ready     = 1'b1;
                    d.st        = acp_pkg::ST_IDLE;
                end
                else
                begin
                    // long count, bus stays open, but the reset code overwrites the code of a command queued here
                    d.cnt = q.cnt - 32'h1;
                end
            end

            acp_pkg::ST_IDLE:
            begin
                if (q.pend)
                begin
                    // commands take priority over the background scan
                    d.pend = wr_value;
                    d.st   = acp_pkg::ST_EXEC;
                end
                else if (q.scan_mode && !conv_busy)
                begin
                    if (q.scan_idx == `ACP_CJ_CHAN)
                    begin
                        d.conv_go   = 1'b1;
                        d.conv_chan = q.scan_idx;
                        d.conv_type = `ACP_TYPE_CJ;
                        d.scan_conv = 1'b1;
                        d.st        = acp_pkg::ST_CONV;
                    end
                    else if (q.ctype[q.scan_idx[3:0]] != `ACP_TYPE_NONE)
                    begin
                        d.conv_go   = 1'b1;
                        d.conv_chan = q.scan_idx;
                        d.conv_type = q.ctype[q.scan_idx[3:0]];
                        d.scan_conv = 1'b1;
                        d.st        = acp_pkg::ST_CONV;
                    end
                    else
                    begin
                        // unassigned channels cost one cycle each in the sweep
                        d.scan_idx = q.scan_idx + 5'h01;
                    end
                end
            end

            acp_pkg::ST_EXEC:
            begin
                finish = 1'b1;
                case (q.loc0)
                    `ACP_CMD_RESET:
                    begin
                        // stop the scan so no slot starts during the sequence
                        finish      = 1'b0;
                        d.scan_mode = 1'b0;
                        d.cnt       = 32'(RESET_CYCLES - 1);
                        d.st        = acp_pkg::ST_RESET;
                    end
                    `ACP_CMD_INIT:
                    begin
                        d.line50    = q.loc2[`ACP_INIT_LINE50_BIT];
                        d.scan_mode = q.loc2[`ACP_INIT_SCAN_BIT];
                        d.scan_idx  = 5'h00;
                    end
                    `ACP_CMD_WR_CHAN:
                    begin
                        // out-of-range pointer is refused, old one kept
                        if (q.loc2 < 8'(`ACP_NUM_CHAN))
                            d.chan_ptr = q.loc2[3:0];
                        else
                            sts = `ACP_STS_ERR_CHAN;
                    end
                    `ACP_CMD_CFG_TYPE:
                    begin
                        // code zero hands a channel back to unassigned
                        if (q.loc2 == `ACP_TYPE_NONE ||
                            acp_pkg::type_class(q.loc2) != acp_pkg::CLS_NONE)
                            d.ctype[q.chan_ptr] = q.loc2;
                        else
                            sts = `ACP_STS_ERR_TYPE;
                    end
                    `ACP_CMD_CFG_SLOPE:
                        d.slope[q.chan_ptr] = {q.loc2, q.loc1};
                    `ACP_CMD_CFG_OFFSET:
                        d.offset[q.chan_ptr] = {q.loc2, q.loc1};
                    `ACP_CMD_READ_SCAN:
                    begin
                        // scan data may be up to one full sweep old
                        if (!q.scan_mode)
                            sts = `ACP_STS_ERR_MODE;
                        else if (q.loc1 >= 8'(`ACP_NUM_CHAN))
                            sts = `ACP_STS_ERR_CHAN;
                        else if (q.ctype[rd_chan] == `ACP_TYPE_NONE)
                            sts = `ACP_STS_ERR_UNASGN;
                        else
                        begin
                            d.loc1 = q.result[rd_chan][7:0];
                            d.loc2 = q.result[rd_chan][15:8];
                        end
                    end
                    `ACP_CMD_READ_DEMAND:
                    begin
                        if (q.loc1 >= 8'(`ACP_NUM_CHAN))
                            sts = `ACP_STS_ERR_CHAN;
                        else if (q.ctype[rd_chan] == `ACP_TYPE_NONE)
                            sts = `ACP_STS_ERR_UNASGN;
                        else
                        begin
                            finish      = 1'b0;
                            d.conv_go   = 1'b1;
                            d.conv_chan = {1'b0, rd_chan};
                            d.conv_type = q.ctype[rd_chan];
                            d.scan_conv = 1'b0;
                            d.st        = acp_pkg::ST_CONV;
                        end
                    end
                    default:
                        sts = `ACP_STS_ERR_CMD;
                endcase
                // immediate commands answer one cycle after decode
                if (finish)
                begin
                    d.loc0  = sts;
                    d.ready = 1'b1;
                    d.st    = acp_pkg::ST_IDLE;
                end
            end

            acp_pkg::ST_CONV:
            begin
                // a queued command waits here until the slot ends
                if (conv_done)
                begin
                    d.st = acp_pkg::ST_IDLE;
                    if (q.scan_conv)
                    begin
                        if (q.conv_chan == `ACP_CJ_CHAN)
                        begin
                            d.cj       = conv_data;
                            d.scan_idx = 5'h00;
                        end
                        else
                        begin
                            d.result[cidx] = scaled;
                            d.scan_idx     = q.scan_idx + 5'h01;
                        end
                    end
                    else
                    begin
                        d.loc1  = scaled[7:0];
                        d.loc2  = scaled[15:8];
                        d.loc0  = `ACP_STS_OK;
                        d.ready = 1'b1;
                    end
                end
            end

            default:
                d.st = acp_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // power-up runs the same sequence as the reset command
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            q     <= '0;
            q.st  <= acp_pkg::ST_RESET;
            q.cnt <= 32'(RESET_CYCLES - 1);
        end
        else
        begin
            q <= d;
        end
    end

    // every output is a plain register copy
    assign RDATA          = q.rdata;
    assign LINE_FREQ_50HZ = q.line50;
    assign CONT_SCAN      = q.scan_mode;
    assign CMD_DONE       = q.ready;

endmodule // acp_command_port

// ---- hw/acp_conv_timer.sv ----
`timescale 1ns/1ps
`include "acp_map.svh"

module acp_conv_timer #(
    parameter int unsigned V14_CYCLES = 1,
    parameter int unsigned V12_CYCLES = 1,
    parameter int unsigned TC_CYCLES  = 1
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        start,
    input  wire logic [4:0]  chan,
    input  wire logic [7:0]  ctype,
    input  wire logic [15:0] fe_data,
    output logic             busy,
    output logic             done,
    output logic [15:0]      data,
    output logic             fe_start,
    output logic [4:0]       fe_chan,
    output logic [7:0]       fe_type
);

    acp_pkg::acp_conv_s q;
    acp_pkg::acp_conv_s d;

    // ----------------------------------------------------------------
    // conversion timing
    // ----------------------------------------------------------------
    always_comb
    begin
        d          = q;
        d.sync1    = fe_data;
        d.sync2    = q.sync1;
        d.fe_start = 1'b0;
        d.done     = 1'b0;
        if (start && !q.busy)
        begin
            d.busy     = 1'b1;
            d.fe_start = 1'b1;
            d.fe_chan  = chan;
            d.fe_type  = ctype;
            case (acp_pkg::type_class(ctype))
                acp_pkg::CLS_V14: d.cnt = 32'(V14_CYCLES - 1);
                acp_pkg::CLS_V12: d.cnt = 32'(V12_CYCLES - 1);
                acp_pkg::CLS_TC:  d.cnt = 32'(TC_CYCLES - 1);
                default:          d.cnt = 32'h0;
            endcase
        end
        else if (q.busy)
        begin
            if (q.cnt == 32'h0)
            begin
                // front end holds its word steady by the end of the slot
                d.busy = 1'b0;
                d.done = 1'b1;
                d.data = q.sync2;
            end
            else
            begin
                d.cnt = q.cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= d;
    end

    assign busy     = q.busy;
    assign done     = q.done;
    assign data     = q.data;
    assign fe_start = q.fe_start;
    assign fe_chan  = q.fe_chan;
    assign fe_type  = q.fe_type;

endmodule // acp_conv_timer

// ---- hw/acp_map.svh ----
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

// ----------------------------------------------------------------
// host locations
// ----------------------------------------------------------------
`define ACP_LOC_STATUS      2'h0
`define ACP_LOC_ARG         2'h1
`define ACP_LOC_VALUE       2'h2
`define ACP_LOC_DONE        2'h3
`define ACP_ADDR_W          8
`define ACP_SW_W            6

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define ACP_CMD_RESET       8'h30
`define ACP_CMD_INIT        8'h31
`define ACP_CMD_WR_CHAN     8'h32
`define ACP_CMD_CFG_TYPE    8'h33
`define ACP_CMD_CFG_SLOPE   8'h34
`define ACP_CMD_CFG_OFFSET  8'h35
`define ACP_CMD_READ_SCAN   8'h36
`define ACP_CMD_READ_DEMAND 8'h37

// ----------------------------------------------------------------
// init value byte fields
// ----------------------------------------------------------------
`define ACP_INIT_LINE50_BIT 0
`define ACP_INIT_SCAN_BIT   1

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define ACP_STS_OK          8'h00
`define ACP_STS_RESET       8'h0d
`define ACP_STS_ERR_CMD     8'h01
`define ACP_STS_ERR_CHAN    8'h02
`define ACP_STS_ERR_TYPE    8'h03
`define ACP_STS_ERR_UNASGN  8'h04
`define ACP_STS_ERR_MODE    8'h05

// ----------------------------------------------------------------
// channels and type codes
// ----------------------------------------------------------------
`define ACP_NUM_CHAN        16
`define ACP_CJ_CHAN         5'h10
`define ACP_TYPE_NONE       8'h00
`define ACP_TYPE_V14_LO     8'h01
`define ACP_TYPE_V14_HI     8'h08
`define ACP_TYPE_V12_LO     8'h0c
`define ACP_TYPE_V12_HI     8'h12
`define ACP_TYPE_TC_LO      8'h15
`define ACP_TYPE_TC_HI      8'h1a
`define ACP_TYPE_CJ         8'h15
`define ACP_SLOPE_RESET     16'h0001
`define ACP_OFFSET_RESET    16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACP_CLK_PERIOD_NS   5
`define ACP_NS_PER_MS       1000000
`define ACP_T_RESET_MS      2500
`define ACP_T_V14_MS        75
`define ACP_T_V12_MS        45
`define ACP_T_TC_MS         110

`endif

// ---- hw/acp_pkg.sv ----
package acp_pkg;

`include "acp_map.svh"

    // gray along idle -> exec -> conv; conv -> idle changes both bits
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_EXEC  = 2'h1,
        ST_CONV  = 2'h3,
        ST_RESET = 2'h2
    } acp_state_e;

    typedef enum logic [1:0] {
        CLS_NONE = 2'h0,
        CLS_V14  = 2'h1,
        CLS_V12  = 2'h2,
        CLS_TC   = 2'h3
    } acp_class_e;

    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [31:0] cnt;
        logic        busy;
        logic        done;
        logic [15:0] data;
        logic        fe_start;
        logic [4:0]  fe_chan;
        logic [7:0]  fe_type;
    } acp_conv_s;

    typedef struct packed {
        acp_state_e        st;
        logic [5:0]        sw1;
        logic [5:0]        sw2;
        logic [7:0]        loc0;
        logic [7:0]        loc1;
        logic [7:0]        loc2;
        logic              ready;
        logic              pend;
        logic [31:0]       cnt;
        logic              line50;
        logic              scan_mode;
        logic [3:0]        chan_ptr;
        logic [15:0][7:0]  ctype;
        logic [15:0][15:0] slope;
        logic [15:0][15:0] offset;
        logic [15:0][15:0] result;
        logic [15:0]       cj;
        logic [4:0]        scan_idx;
        logic              scan_conv;
        logic              conv_go;
        logic [4:0]        conv_chan;
        logic [7:0]        conv_type;
        logic [7:0]        rdata;
    } acp_top_s;

    // type code to conversion class, shared by both modules
    function automatic acp_class_e type_class(input logic [7:0] code);
        if (code >= `ACP_TYPE_V14_LO && code <= `ACP_TYPE_V14_HI)
            return CLS_V14;
        else if (code >= `ACP_TYPE_V12_LO && code <= `ACP_TYPE_V12_HI)
            return CLS_V12;
        else if (code >= `ACP_TYPE_TC_LO && code <= `ACP_TYPE_TC_HI)
            return CLS_TC;
        else
            return CLS_NONE;
    endfunction

endpackage

// ---- tb/acp_command_port_props.sv ----
`timescale 1ns/1ps

module acp_command_port_props (
    input wire logic [7:0] ADDR,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic [5:0] BASE_ADDRESS_SWITCH,
    input wire logic       FE_START,
    input wire logic [4:0] FE_CHAN,
    input wire logic [7:0] FE_TYPE,
    input wire logic       CMD_DONE,
    input wire logic       CLOCK,
    input wire logic       RESETN
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    // switch is static in the bench, so its sync delay does not matter here
    logic hit;
    assign hit = (ADDR[7:2] == BASE_ADDRESS_SWITCH);

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    AST_UNMAPPED_READ: assert property (RD && !hit |=> RDATA == 8'h00)
        else $error("unmapped read returned data");
    AST_RDATA_ONLY_AFTER_RD: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data outside its cycle");
    AST_VALUE_WRITE_CLEARS_DONE: assert property (
        WR && hit && ADDR[1:0] == 2'h2 |=> !CMD_DONE [*2])
        else $error("done flag not cleared by value write");
    AST_DONE_READBACK: assert property (
        RD && hit && ADDR[1:0] == 2'h3 |=> RDATA == {7'h00, $past(CMD_DONE)})
        else $error("done location reads wrong");
    AST_DONE_HOLDS: assert property (
        CMD_DONE && !(WR && hit && ADDR[1:0] == 2'h2) |=> CMD_DONE)
        else $error("done flag dropped without a command");
    AST_POWERUP_BUSY: assert property ($rose(RESETN) |-> !CMD_DONE [*8])
        else $error("done set too early after reset");
    AST_SLOT_PULSE: assert property (FE_START |=> !FE_START)
        else $error("conversion start longer than one cycle");
    AST_SLOT_STEADY: assert property (
        FE_START |=> ($stable(FE_CHAN) && $stable(FE_TYPE)) [*4])
        else $error("slot channel or type moved");
    AST_NO_UNASSIGNED_CONV: assert property (FE_START |-> FE_TYPE != 8'h00)
        else $error("conversion on unassigned channel");

    CV_SLOT: cover property (FE_START);
    CV_CJ_SLOT: cover property (FE_START && FE_CHAN == 5'h10);
    CV_DONE_RISE: cover property (!CMD_DONE ##1 CMD_DONE);
endmodule // acp_command_port_props

bind acp_command_port acp_command_port_props u_props (
    .ADDR               (ADDR),
    .WR                 (WR),
    .RD                 (RD),
    .RDATA              (RDATA),
    .BASE_ADDRESS_SWITCH(BASE_ADDRESS_SWITCH),
    .FE_START           (FE_START),
    .FE_CHAN            (FE_CHAN),
    .FE_TYPE            (FE_TYPE),
    .CMD_DONE           (CMD_DONE),
    .CLOCK              (CLOCK),
    .RESETN             (RESETN)
);

// ---- tb/acp_fe_model.sv ----
`timescale 1ns/1ps

module acp_fe_model (
    input  wire logic        clock,
    input  wire logic        fe_start,
    input  wire logic [4:0]  fe_chan,
    output logic      [15:0] fe_data
);
    // ----------------------------------------
    // converter
    // ----------------------------------------
    // reading is 0x0100 plus channel, held for the whole slot so the
    // two-stage sync in the block always sees a settled value
    initial fe_data = 16'h0000;
    always @(posedge clock)
    begin
        if (fe_start)
            fe_data <= 16'h0100 + {11'h000, fe_chan};
    end
endmodule // acp_fe_model

// ---- tb/test_analog_input_command_port.sv ----
`timescale 1ns/1ps

module test_analog_input_command_port;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [15:0] fe_data;
    logic        fe_start;
    logic [4:0]  fe_chan;
    logic        line50;
    logic        scan;
    logic        done;
    logic [7:0]  v;
    int          fails = 0;
    int          total_checks = 0;
    localparam logic [7:0] BASE = 8'ha8;

    always #2.5 clock = ~clock;

    acp_command_port #(.RESET_CYCLES(20), .V14_CYCLES(8), .V12_CYCLES(5),
                       .TC_CYCLES(12)) uut (
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .BASE_ADDRESS_SWITCH(6'h2a), .FE_DATA(fe_data), .FE_START(fe_start),
        .FE_CHAN(fe_chan), .FE_TYPE(), .LINE_FREQ_50HZ(line50),
        .CONT_SCAN(scan), .CMD_DONE(done), .CLOCK(clock), .RESETN(resetn));

    acp_fe_model fe (.clock(clock), .fe_start(fe_start), .fe_chan(fe_chan),
                     .fe_data(fe_data));

    // ----------------------------------------
    // host bus
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // polling bounded; a stuck flag is caught by the done-flag check in cmd
    task automatic wait_done();
        v = 8'h00;
        for (int i = 0; i < 400 && v !== 8'h01; i++)
            rd_b(BASE + 8'h3, v);
    endtask

    task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] x,
                       input logic [7:0] sts);
        wr_b(BASE, c);
        wr_b(BASE + 8'h1, a);
        wr_b(BASE + 8'h2, x);
        rd_b(BASE + 8'h3, v);
        chk(v, 8'h00);
        wait_done();
        chk(v, 8'h01);
        rd_b(BASE, v);
        chk(v, sts);
    endtask

    task automatic read_val(input logic [7:0] c, input logic [7:0] ch, input logic [15:0] exp);
        cmd(c, ch, 8'h00, 8'h00);
        rd_b(BASE + 8'h1, v);
        chk(v, exp[7:0]);
        rd_b(BASE + 8'h2, v);
        chk(v, exp[15:8]);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_powerup();
        rd_b(BASE + 8'h3, v);
        chk(v, 8'h00);
        wait_done();
        rd_b(BASE, v);
        chk(v, 8'h0d);
    endtask

    task automatic t_bus();
        rd_b(8'h10, v);
        chk(v, 8'h00);
        wr_b(BASE + 8'h3, 8'h00);
        rd_b(BASE + 8'h3, v);
        chk(v, 8'h01);
        wr_b(BASE + 8'h1, 8'h5a);
        rd_b(BASE + 8'h1, v);
        chk(v, 8'h5a);
    endtask

    task automatic t_config();
        cmd(8'h30, 8'h00, 8'h00, 8'h0d);
        cmd(8'h31, 8'h00, 8'h01, 8'h00);
        chk({6'h00, scan, line50}, 8'h01);
        cmd(8'h7f, 8'h00, 8'h00, 8'h01);
        cmd(8'h32, 8'h00, 8'h10, 8'h02);
    endtask

    task automatic t_demand();
        logic [7:0] codes [4] = '{8'h01, 8'h08, 8'h0c, 8'h12};
        cmd(8'h37, 8'h05, 8'h00, 8'h04);
        cmd(8'h32, 8'h00, 8'h04, 8'h00);
        cmd(8'h33, 8'h00, 8'h1a, 8'h00);
        read_val(8'h37, 8'h04, 16'h0104);
        cmd(8'h32, 8'h00, 8'h03, 8'h00);
        cmd(8'h33, 8'h00, 8'h09, 8'h03);
        for (int i = 0; i < 4; i++)
            cmd(8'h33, 8'h00, codes[i], 8'h00);
        cmd(8'h34, 8'h02, 8'h00, 8'h00);
        cmd(8'h35, 8'h05, 8'h00, 8'h00);
        read_val(8'h37, 8'h03, 16'h020b);
    endtask

    task automatic t_scan();
        cmd(8'h31, 8'h00, 8'h02, 8'h00);
        chk({6'h00, scan, line50}, 8'h02);
        repeat (200) @(posedge clock);
        read_val(8'h36, 8'h03, 16'h020b);
        read_val(8'h36, 8'h04, 16'h0104);
    endtask

    task automatic t_reset();
        cmd(8'h30, 8'h00, 8'h00, 8'h0d);
        chk({7'h00, scan}, 8'h00);
        cmd(8'h31, 8'h00, 8'h00, 8'h00);
        cmd(8'h37, 8'h03, 8'h00, 8'h04);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic report_and_stop();
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        // the switch synchroniser needs two edges before the first hit
        repeat (2) @(posedge clock);
        t_powerup();
        t_bus();
        t_config();
        t_demand();
        t_scan();
        t_reset();
        report_and_stop();
    end

    // whole run is well under this span
    initial
    begin
        repeat (60000) @(posedge clock);
        fails++;
        report_and_stop();
    end
endmodule // test_analog_input_command_port
